// File: rtl/ac_link_global_control_defs.svh
// constants for the global link control block: offsets, fields, resets, timing
// Notes on behaviour
// - bits 21:20 pick two, four, six channels
// - bit 5 enables secondary resume interrupt
// - bit 4 enables primary resume interrupt
// - shutoff bit forces outputs low, inputs off
// - writing warm bit issues link warm reset
// - warm write ignored while bit clock runs
// - warm bit self-clears once bit clock seen
// - cold bit zero resets all link circuitry
// - cold bit kept in resume power domain
// - input change sets status, gated interrupt
// - resume event sets flag, write one clears
`ifndef AC_LINK_GLOBAL_CONTROL_DEFS_SVH
`define AC_LINK_GLOBAL_CONTROL_DEFS_SVH

// byte offsets from bus_master_io_base
`define GLC_OFS_CTRL     8'h2C
`define GLC_OFS_STAT     8'h30

// control field positions
`define GLC_CH_HI        21
`define GLC_CH_LO        20
`define GLC_SEC_RES_EN   5
`define GLC_PRIM_RES_EN  4
`define GLC_SHUTOFF      3
`define GLC_WARM         2
`define GLC_COLD_N       1
`define GLC_CHG_IRQ_EN   0

// status field positions
`define GLS_CAP6         21
`define GLS_CAP4         20
`define GLS_SEC_RES      11
`define GLS_PRIM_RES     10
`define GLS_IN_CHG       0

// reset values
`define GLC_CTRL_RST     32'h0000_0000
`define GLC_CH_RST       2'h0
`define GLC_CH_RSVD      2'h3

// timing: core clock, warm pulse, bit clock idle window
`define GLC_CLK_NS       25
`define GLC_WARM_NS      1000
`define GLC_WARM_CYC     ((`GLC_WARM_NS + `GLC_CLK_NS - 1) / `GLC_CLK_NS)
`define GLC_IDLE_NS      1000
`define GLC_IDLE_CYC     (`GLC_IDLE_NS / `GLC_CLK_NS)
`define GLC_NGPI         8

`endif

// File: rtl/ac_link_global_control_pkg.sv
// types shared by the global link control block
package ac_link_global_control_pkg;
    // software visible control fields
    typedef struct packed {
        logic [1:0] chan;          // pcm channel count select
        logic       sec_res_en;    // secondary resume irq enable
        logic       prim_res_en;   // primary resume irq enable
        logic       shutoff;       // link shutoff
        logic       warm;          // warm reset in progress
        logic       chg_irq_en;    // input change irq enable
    } ctrl_s;

    // link output pins
    typedef struct packed {
        logic sync;
        logic sdata;
        logic reset_n;
    } link_out_s;

    // warm reset sequencer
    typedef enum logic [2:0] {
        WS_IDLE  = 3'b001,
        WS_PULSE = 3'b010,
        WS_WAIT  = 3'b100
    } warm_state_e;
endpackage

// File: rtl/ac_link_global_control.sv
// global control and resume status logic of the ac-link controller
`timescale 1ns/1ps
`include "ac_link_global_control_defs.svh"

module ac_link_global_control (
    // clock and resets
    input  wire logic                     clk_in,
    input  wire logic                     rst_in,
    input  wire logic                     resume_rst_in,
    // register port
    input  wire logic [7:0]               io_addr_in,
    input  wire logic                     io_wr_in,
    input  wire logic                     io_rd_in,
    input  wire logic [3:0]               io_be_in,
    input  wire logic [31:0]              io_wdata_in,
    output logic      [31:0]              io_rdata_out,
    // link pins
    input  wire logic                     bit_clk_in,
    input  wire logic [1:0]               codec_serial_input_in,
    input  wire logic                     frame_sdata_in,
    input  wire logic                     frame_sync_in,
    output logic                          link_sync_out,
    output logic                          link_sdata_out,
    output logic                          link_reset_n_out,
    // system side
    input  wire logic [`GLC_NGPI-1:0]     general_purpose_input_in,
    output logic      [1:0]               pcm_chan_out,
    output logic                          link_rst_out,
    output logic                          irq_out
);

    ////////////////////////////////////////////////////////////////////////
    // constants
    localparam logic [7:0] WARM_CYC = 8'(`GLC_WARM_CYC);
    localparam logic [7:0] IDLE_CYC = 8'(`GLC_IDLE_CYC);

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers: first stage feeds only the second
    logic [1:0]               sdin_s1_r, sdin_s2_r, sdin_s3_r;    // codec inputs
    logic                     bclk_s1_r, bclk_s2_r, bclk_s3_r;    // bit clock
    logic [`GLC_NGPI-1:0]     gpin_s1_r, gpin_s2_r, gpin_s3_r;    // gp inputs

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            sdin_s1_r <= 2'h0;
            sdin_s2_r <= 2'h0;
            sdin_s3_r <= 2'h0;
            bclk_s1_r <= 1'b0;
            bclk_s2_r <= 1'b0;
            bclk_s3_r <= 1'b0;
            gpin_s1_r <= '0;
            gpin_s2_r <= '0;
            gpin_s3_r <= '0;
        end else begin
            sdin_s1_r <= codec_serial_input_in;
            sdin_s2_r <= sdin_s1_r;
            sdin_s3_r <= sdin_s2_r;
            bclk_s1_r <= bit_clk_in;
            bclk_s2_r <= bclk_s1_r;
            bclk_s3_r <= bclk_s2_r;
            gpin_s1_r <= general_purpose_input_in;
            gpin_s2_r <= gpin_s1_r;
            gpin_s3_r <= gpin_s2_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state declarations
    ac_link_global_control_pkg::ctrl_s       ctrl_r, ctrl_nxt;     // control
    logic                                    cold_n_r, cold_n_nxt; // resume well
    ac_link_global_control_pkg::warm_state_e ws_r, ws_nxt;         // warm fsm
    logic [7:0]                              wcnt_r, wcnt_nxt;     // pulse timer
    logic [7:0]                              idle_r, idle_nxt;     // since edge
    logic [1:0]                              res_r, res_nxt;       // resume flags
    logic                                    chg_r, chg_nxt;       // input change
    logic [31:0]                             rdata_nxt;
    ac_link_global_control_pkg::link_out_s   lo_r, lo_nxt;
    logic                                    irq_nxt;

    // qualified inputs: shutoff turns the input buffers off
    logic                                    shut;
    logic                                    bclk_edge;
    logic                                    running;
    logic [1:0]                              sdin_rise;
    logic                                    wr_ctrl, wr_stat;
    logic                                    link_rst;

    assign shut      = ctrl_r.shutoff;
    assign link_rst  = ~cold_n_r;
    assign bclk_edge = ~shut & (bclk_s2_r ^ bclk_s3_r);
    assign running   = (idle_r < IDLE_CYC);
    assign wr_ctrl   = io_wr_in & (io_addr_in == `GLC_OFS_CTRL);
    assign wr_stat   = io_wr_in & (io_addr_in == `GLC_OFS_STAT);

    // resume is signalled by a codec raising its data line while the clock is down
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_resume
            assign sdin_rise[gi] = ~shut & ~running & sdin_s2_r[gi] & ~sdin_s3_r[gi];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // bit clock activity: counts cycles since the last seen edge
    always_comb begin
        idle_nxt = idle_r;
        if (link_rst || bclk_edge) begin
            idle_nxt = 8'h00;
        end else if (idle_r != 8'hFF) begin
            idle_nxt = idle_r + 8'h01;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            idle_r <= 8'hFF;
        end else begin
            idle_r <= idle_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control register and warm reset sequencer
    always_comb begin
        ctrl_nxt = ctrl_r;
        ws_nxt   = ws_r;
        wcnt_nxt = wcnt_r;
        // software writes by byte lane
        if (wr_ctrl && io_be_in[2]) begin
            ctrl_nxt.chan = io_wdata_in[`GLC_CH_HI:`GLC_CH_LO];
        end
        if (wr_ctrl && io_be_in[0]) begin
            ctrl_nxt.sec_res_en  = io_wdata_in[`GLC_SEC_RES_EN];
            ctrl_nxt.prim_res_en = io_wdata_in[`GLC_PRIM_RES_EN];
            ctrl_nxt.shutoff     = io_wdata_in[`GLC_SHUTOFF];
            ctrl_nxt.chg_irq_en  = io_wdata_in[`GLC_CHG_IRQ_EN];
            // a warm request only counts while the bit clock is stopped
            if (io_wdata_in[`GLC_WARM] && !running && !ctrl_r.warm) begin
                ctrl_nxt.warm = 1'b1;
                ws_nxt        = ac_link_global_control_pkg::WS_PULSE;
                wcnt_nxt      = 8'h00;
            end
        end
        case (ws_r)
            ac_link_global_control_pkg::WS_IDLE: begin
                wcnt_nxt = 8'h00;
            end
            ac_link_global_control_pkg::WS_PULSE: begin
                // hold sync high for the warm pulse width
                wcnt_nxt = wcnt_r + 8'h01;
                if (wcnt_r == WARM_CYC - 8'h01) begin
                    ws_nxt = ac_link_global_control_pkg::WS_WAIT;
                end
            end
            ac_link_global_control_pkg::WS_WAIT: begin
                // done once the codec's clock is back on the link
                if (bclk_edge) begin
                    ctrl_nxt.warm = 1'b0;
                    ws_nxt        = ac_link_global_control_pkg::WS_IDLE;
                end
            end
            default: begin
                ws_nxt = ac_link_global_control_pkg::WS_IDLE;
            end
        endcase
        // cold reset aborts any warm sequence
        if (link_rst) begin
            ctrl_nxt.warm = 1'b0;
            ws_nxt        = ac_link_global_control_pkg::WS_IDLE;
            wcnt_nxt      = 8'h00;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ctrl_r <= '0;
            ws_r   <= ac_link_global_control_pkg::WS_IDLE;
            wcnt_r <= 8'h00;
        end else begin
            ctrl_r <= ctrl_nxt;
            ws_r   <= ws_nxt;
            wcnt_r <= wcnt_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // cold reset bit: reset only by the resume well, so core resets keep it
    always_comb begin
        cold_n_nxt = cold_n_r;
        if (wr_ctrl && io_be_in[0]) begin
            cold_n_nxt = io_wdata_in[`GLC_COLD_N];
        end
    end

    always_ff @(posedge clk_in) begin
        if (resume_rst_in) begin
            cold_n_r <= 1'b0;
        end else begin
            cold_n_r <= cold_n_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sticky status flags: a set in the clearing cycle wins
    always_comb begin
        res_nxt = res_r;
        chg_nxt = chg_r;
        if (wr_stat && io_be_in[1]) begin
            res_nxt = res_r & ~io_wdata_in[`GLS_SEC_RES:`GLS_PRIM_RES];
        end
        if (wr_stat && io_be_in[0] && io_wdata_in[`GLS_IN_CHG]) begin
            chg_nxt = 1'b0;
        end
        res_nxt = res_nxt | {sdin_rise[1], sdin_rise[0]};
        if (gpin_s2_r != gpin_s3_r) begin
            chg_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            res_r <= 2'h0;
            chg_r <= 1'b0;
        end else begin
            res_r <= res_nxt;
            chg_r <= chg_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs: link pins, read data, interrupt, all registered
    always_comb begin
        lo_nxt.sync    = frame_sync_in | ws_r[1];
        lo_nxt.sdata   = frame_sdata_in;
        lo_nxt.reset_n = cold_n_r;
        if (link_rst) begin
            lo_nxt.sync  = 1'b0;
            lo_nxt.sdata = 1'b0;
        end
        if (shut) begin
            lo_nxt = '0;
        end
        irq_nxt = (res_r[1] & ctrl_r.sec_res_en)
                | (res_r[0] & ctrl_r.prim_res_en)
                | (chg_r & ctrl_r.chg_irq_en);
        rdata_nxt = 32'h0000_0000;
        if (io_rd_in && io_addr_in == `GLC_OFS_CTRL) begin
            rdata_nxt[`GLC_CH_HI:`GLC_CH_LO] = ctrl_r.chan;
            rdata_nxt[`GLC_SEC_RES_EN]  = ctrl_r.sec_res_en;
            rdata_nxt[`GLC_PRIM_RES_EN] = ctrl_r.prim_res_en;
            rdata_nxt[`GLC_SHUTOFF]     = ctrl_r.shutoff;
            rdata_nxt[`GLC_WARM]        = ctrl_r.warm;
            rdata_nxt[`GLC_COLD_N]      = cold_n_r;
            rdata_nxt[`GLC_CHG_IRQ_EN]  = ctrl_r.chg_irq_en;
        end else if (io_rd_in && io_addr_in == `GLC_OFS_STAT) begin
            rdata_nxt[`GLS_CAP6]     = 1'b1;
            rdata_nxt[`GLS_CAP4]     = 1'b1;
            rdata_nxt[`GLS_SEC_RES]  = res_r[1];
            rdata_nxt[`GLS_PRIM_RES] = res_r[0];
            rdata_nxt[`GLS_IN_CHG]   = chg_r;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            lo_r         <= '0;
            irq_out      <= 1'b0;
            io_rdata_out <= 32'h0000_0000;
            pcm_chan_out <= `GLC_CH_RST;
            link_rst_out <= 1'b1;
        end else begin
            lo_r         <= lo_nxt;
            irq_out      <= irq_nxt;
            io_rdata_out <= rdata_nxt;
            pcm_chan_out <= ctrl_r.chan;
            link_rst_out <= link_rst;
        end
    end

    assign link_sync_out    = lo_r.sync;
    assign link_sdata_out   = lo_r.sdata;
    assign link_reset_n_out = lo_r.reset_n;

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_chan_follow: assert property (@(posedge clk_in) disable iff (rst_in)
        wr_ctrl && io_be_in[2]
        |-> ##2 pcm_chan_out == $past(io_wdata_in[`GLC_CH_HI:`GLC_CH_LO], 2))
        else $error("channel select not applied");
    a_warm_ignored: assert property (@(posedge clk_in) disable iff (rst_in)
        wr_ctrl && io_be_in[0] && io_wdata_in[`GLC_WARM] && running && !ctrl_r.warm
        |=> !ctrl_r.warm)
        else $error("warm write taken while clock runs");
    // a write that also drops the cold bit or sets shutoff keeps sync low on purpose
    a_warm_taken: assert property (@(posedge clk_in) disable iff (rst_in)
        wr_ctrl && io_be_in[0] && io_wdata_in[`GLC_WARM] && io_wdata_in[`GLC_COLD_N]
        && !io_wdata_in[`GLC_SHUTOFF] && !running && !link_rst && !ctrl_r.warm
        |=> ctrl_r.warm ##2 link_sync_out)
        else $error("warm reset not issued");
    a_warm_hold: assert property (@(posedge clk_in) disable iff (rst_in)
        $fell(ctrl_r.warm) |-> $past(bclk_edge) || $past(link_rst))
        else $error("warm bit cleared without bit clock");
    a_shut_low: assert property (@(posedge clk_in) disable iff (rst_in)
        shut |=> !link_sync_out && !link_sdata_out && !link_reset_n_out)
        else $error("link pin high during shutoff");
    a_cold_pin: assert property (@(posedge clk_in) disable iff (rst_in)
        !cold_n_r && !shut |=> !link_reset_n_out && !link_sync_out)
        else $error("link not held in cold reset");
    a_cold_keep: assert property (@(posedge clk_in) disable iff (resume_rst_in)
        !wr_ctrl |=> cold_n_r == $past(cold_n_r))
        else $error("cold bit lost its value");
    a_resume_set: assert property (@(posedge clk_in) disable iff (rst_in)
        sdin_rise[0] |=> res_r[0] ##1 (irq_out || !ctrl_r.prim_res_en))
        else $error("primary resume not flagged");
    a_sec_mask: assert property (@(posedge clk_in) disable iff (rst_in)
        !ctrl_r.sec_res_en && !(res_r[0] && ctrl_r.prim_res_en)
        && !(chg_r && ctrl_r.chg_irq_en)
        |=> !irq_out)
        else $error("masked interrupt raised");
    a_change_set: assert property (@(posedge clk_in) disable iff (rst_in)
        gpin_s2_r != gpin_s3_r |=> chg_r)
        else $error("input change not flagged");

endmodule // ac_link_global_control

// File: verif/codec_pair_model.sv
// behavioural model of the primary and secondary codecs on the link
`timescale 1ns/1ps
module codec_pair_model (
    // pins from the controller
    input  wire logic       sync_in,
    input  wire logic       reset_n_in,
    // bench commands
    input  wire logic       sleep_in,
    input  wire logic [1:0] wake_in,
    // pins to the controller
    output logic            bit_clk_out,
    output logic [1:0]      sdin_out
);
    logic awake;  // codec powered and clocking

    ////////////////////////////////////////////////////////////////////////
    // power state
    initial awake = 1'b0;
    // cold reset drops the codec, its release boots it
    always @(negedge reset_n_in) awake = 1'b0;
    always @(posedge reset_n_in) awake = 1'b1;
    // suspend stops the bit clock
    always @(posedge sleep_in) awake = 1'b0;
    // end of a warm pulse wakes a suspended codec, registers kept
    always @(negedge sync_in) if (reset_n_in) awake = 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // bit clock, 200 ns, off phase to the core clock; stands low when asleep
    initial begin
        bit_clk_out = 1'b0;
        #13;
        forever begin
            #100;
            bit_clk_out = awake ? ~bit_clk_out : 1'b0;
        end
    end

    // resume event: data line raised only while the clock stands still
    assign sdin_out = wake_in & {2{~awake}};
endmodule // codec_pair_model

// File: verif/tb_top.sv
// self-checking bench for the global link control block
`timescale 1ns/1ps
`include "ac_link_global_control_defs.svh"
module tb_top;
    logic        clk_in, rst_in, resume_rst_in;    // clock and resets
    logic [7:0]  io_addr_in;                       // register port
    logic        io_wr_in, io_rd_in;
    logic [3:0]  io_be_in;
    logic [31:0] io_wdata_in, io_rdata_out;
    logic        bit_clk, frame_sdata_in, frame_sync_in;  // link
    logic [1:0]  sdin, wake, pcm_chan_out;
    logic        link_sync_out, link_sdata_out, link_reset_n_out;
    logic        link_rst_out, irq_out, sleep;
    logic [7:0]  gp_in;                            // general purpose inputs
    logic [31:0] rv;                               // read-back scratch
    int          fails, num_checks, i, n, fb, eb, sync_run, sync_len;

    ////////////////////////////////////////////////////////////////////////
    // clock, design and partner
    always #12.5 clk_in = ~clk_in;

    ac_link_global_control u_ac_link_global_control (
        .clk_in(clk_in), .rst_in(rst_in), .resume_rst_in(resume_rst_in),
        .io_addr_in(io_addr_in), .io_wr_in(io_wr_in), .io_rd_in(io_rd_in),
        .io_be_in(io_be_in), .io_wdata_in(io_wdata_in), .io_rdata_out(io_rdata_out),
        .bit_clk_in(bit_clk), .codec_serial_input_in(sdin),
        .frame_sdata_in(frame_sdata_in), .frame_sync_in(frame_sync_in),
        .link_sync_out(link_sync_out), .link_sdata_out(link_sdata_out),
        .link_reset_n_out(link_reset_n_out), .general_purpose_input_in(gp_in),
        .pcm_chan_out(pcm_chan_out), .link_rst_out(link_rst_out), .irq_out(irq_out));

    codec_pair_model u_codec_pair_model (
        .sync_in(link_sync_out), .reset_n_in(link_reset_n_out), .sleep_in(sleep),
        .wake_in(wake), .bit_clk_out(bit_clk), .sdin_out(sdin));

    // length of the last warm pulse, counted in core cycles
    always @(posedge clk_in) begin
        if (link_sync_out === 1'b1) begin
            sync_run <= sync_run + 1;
        end else if (sync_run != 0) begin
            sync_len <= sync_run;
            sync_run <= 0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // access tasks: strobes change at the falling edge, one cycle long
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge clk_in);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge clk_in);
        io_addr_in  = a;
        io_wdata_in = d;
        io_wr_in    = 1'b1;
        @(negedge clk_in);
        io_wr_in    = 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(negedge clk_in);
        io_addr_in = a;
        io_rd_in   = 1'b1;
        @(negedge clk_in);
        io_rd_in   = 1'b0;
        d          = io_rdata_out;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string nm);
        logic [31:0] d;
        rd(a, d);
        chk(nm, d, exp);
    endtask
    // let the codec fall asleep long enough for the idle window to expire
    task automatic nap;
        cyc(4);
        sleep = 1'b1;
        cyc(60);
        sleep = 1'b0;
    endtask
    task automatic wrap_up;
        if (fails == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // watchdog well beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk_in);
        fails++;
        wrap_up;
    end

    ////////////////////////////////////////////////////////////////////////
    // test sequence
    initial begin
        {clk_in, io_wr_in, io_rd_in, frame_sdata_in, frame_sync_in, sleep} = '0;
        {rst_in, resume_rst_in} = 2'b11;
        {io_addr_in, io_wdata_in, wake, gp_in, sync_run, sync_len} = '0;
        {fails, num_checks} = '0;
        io_be_in = 4'hF;
        repeat (16) @(posedge clk_in);
        @(negedge clk_in);
        {rst_in, resume_rst_in} = 2'b00;
        // reset values and an unmapped place
        rdc(`GLC_OFS_CTRL, 32'h0000_0000, "ctrl_reset");
        rdc(`GLC_OFS_STAT, 32'h0030_0000, "stat_reset");
        chk("reset_pin", {31'h0, link_reset_n_out}, 32'h0);
        rdc(8'h40, 32'h0000_0000, "unmapped");
        // release of cold reset, only after it has been held since reset
        wr(`GLC_OFS_CTRL, 32'h0000_0002);
        cyc(2);
        chk("link_rst", {31'h0, link_rst_out}, 32'h0);
        // pins pass framing, shutoff forces all low
        {frame_sync_in, frame_sdata_in} = 2'b11;
        cyc(3);
        chk("pins_on", {30'h0, link_sync_out, link_sdata_out}, 32'h3);
        wr(`GLC_OFS_CTRL, 32'h0000_000A);
        cyc(2);
        chk("pins_off", {29'h0, link_sync_out, link_sdata_out, link_reset_n_out}, 32'h0);
        wr(`GLC_OFS_CTRL, 32'h0000_0002);
        {frame_sync_in, frame_sdata_in} = 2'b00;
        cyc(20);
        // warm reset refused while the bit clock runs
        wr(`GLC_OFS_CTRL, 32'h0000_0006);
        rdc(`GLC_OFS_CTRL, 32'h0000_0002, "warm_refused");
        // every channel code, then a write that leaves byte 2 disabled
        for (i = 0; i < 3; i++) begin
            wr(`GLC_OFS_CTRL, 32'h0000_0002 | (i << 20));
            cyc(2);
            chk("pcm_chan", {30'h0, pcm_chan_out}, i);
            rdc(`GLC_OFS_CTRL, 32'h0000_0002 | (i << 20), "chan_field");
        end
        io_be_in = 4'h1;
        wr(`GLC_OFS_CTRL, 32'h0000_0002);
        io_be_in = 4'hF;
        rdc(`GLC_OFS_CTRL, 32'h0020_0002, "byte_enable");
        // warm reset on a stopped clock, self-clear once the clock returns
        nap;
        wr(`GLC_OFS_CTRL, 32'h0000_0006);
        rdc(`GLC_OFS_CTRL, 32'h0000_0006, "warm_set");
        rv = 32'h4;
        for (n = 0; n < 80 && rv[2] !== 1'b0; n++) rd(`GLC_OFS_CTRL, rv);
        chk("warm_clear", rv, 32'h0000_0002);
        chk("warm_held", {31'h0, n > 19}, 32'h1);
        chk("warm_pulse", sync_len, `GLC_WARM_CYC);
        // primary data line ignored during shutoff
        wr(`GLC_OFS_CTRL, 32'h0000_000A);
        cyc(50);
        wake = 2'b01;
        cyc(8);
        wake = 2'b00;
        rdc(`GLC_OFS_STAT, 32'h0030_0000, "shutoff_input");
        wr(`GLC_OFS_CTRL, 32'h0000_0002);
        nap;
        // primary, secondary resume and input change: flag, mask, clear
        for (i = 0; i < 3; i++) begin
            fb = (i == 2) ? 0 : 10 + i;
            eb = (i == 2) ? 0 : 4 + i;
            if (i < 2) wake[i] = 1'b1;
            else gp_in = ~gp_in;
            cyc(8);
            wake = 2'b00;
            rdc(`GLC_OFS_STAT, 32'h0030_0000 | (1 << fb), "event_flag");
            chk("irq_masked", {31'h0, irq_out}, 32'h0);
            wr(`GLC_OFS_CTRL, 32'h0000_0002 | (1 << eb));
            cyc(2);
            chk("irq_enabled", {31'h0, irq_out}, 32'h1);
            wr(`GLC_OFS_STAT, 1 << fb);
            cyc(2);
            chk("irq_cleared", {31'h0, irq_out}, 32'h0);
            rdc(`GLC_OFS_STAT, 32'h0030_0000, "flag_cleared");
            wr(`GLC_OFS_CTRL, 32'h0000_0002);
        end
        // core reset keeps the cold bit, software and resume reset clear it
        wr(`GLC_OFS_CTRL, 32'h0010_0002);
        rst_in = 1'b1;
        cyc(2);
        rst_in = 1'b0;
        rdc(`GLC_OFS_CTRL, 32'h0000_0002, "cold_kept");
        chk("link_rst_kept", {31'h0, link_rst_out}, 32'h0);
        wr(`GLC_OFS_CTRL, 32'h0000_0000);
        cyc(2);
        chk("cold_again", {30'h0, link_rst_out, link_reset_n_out}, 32'h2);
        wr(`GLC_OFS_CTRL, 32'h0000_0002);
        resume_rst_in = 1'b1;
        cyc(2);
        resume_rst_in = 1'b0;
        rdc(`GLC_OFS_CTRL, 32'h0000_0000, "resume_reset");
        wrap_up;
    end
endmodule // tb_top
